/* File: hw/sensorless_bldc_loop_config.v */
/*
 * Closed-loop settings of a sensorless motor controller and the
 * speed pulse, stop, commutation switch and
 * current limit logic they steer.
 * Assumes inputs synchronous to mclk and a power stage
 * that obeys the stage outputs.
 */
`timescale 1ns/1ps
`include "loop_config_regs.vh"

module sensorless_bldc_loop_config #(
    parameter TICK_CYCLES = `MS_IN_NS / `CLK_PERIOD_NS
) (
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_we,
    input wire reg_re,
    output reg [31:0] reg_rdata,
    input wire half_period_event,
    input wire closed_loop,
    input wire first_attempt,
    input wire motor_driven,
    input wire [7:0] emf_mv,
    input wire [9:0] duty_pm,
    input wire [7:0] samples_per_30,
    input wire stop_request,
    input wire brake_pin,
    input wire fast_decel_active,
    output wire speed_pulse_output,
    output reg stage_hiz,
    output reg stage_recirc,
    output reg stage_low_brake,
    output reg stage_high_brake,
    output reg stage_spin_down,
    output reg stop_done,
    output reg on_integration,
    output reg [11:0] falling_integration_threshold,
    output reg [11:0] rising_integration_threshold,
    output reg [2:0] degauss_sample_count,
    output reg [7:0] degauss_lower_mv,
    output reg [7:0] degauss_upper_drop_mv,
    output reg comparator_blank,
    output reg [9:0] fast_decel_window_pm,
    output reg [9:0] fast_decel_threshold_pm,
    output reg [10:0] current_limit_mv
);

// ==========================================================================
// Decode functions.

// Emf threshold in mV; unused codes give the largest.
function [7:0] emf_mv_of;
    input [2:0] code;
    begin
        case (code)
            3'h0: emf_mv_of = 8'h01;
            3'h1: emf_mv_of = 8'h02;
            3'h2: emf_mv_of = 8'h05;
            3'h3: emf_mv_of = 8'h0A;
            3'h4: emf_mv_of = 8'h14;
            default: emf_mv_of = 8'h1E;
        endcase
    end
endfunction

// Brake time in ms.
function [13:0] brake_ms_of;
    input [3:0] code;
    begin
        case (code)
            4'h0: brake_ms_of = 14'h0001;
            4'h1: brake_ms_of = 14'h0002;
            4'h2: brake_ms_of = 14'h0005;
            4'h3: brake_ms_of = 14'h000A;
            4'h4: brake_ms_of = 14'h000F;
            4'h5: brake_ms_of = 14'h0019;
            4'h6: brake_ms_of = 14'h0032;
            4'h7: brake_ms_of = 14'h004B;
            4'h8: brake_ms_of = 14'h0064;
            4'h9: brake_ms_of = 14'h00FA;
            4'hA: brake_ms_of = 14'h01F4;
            4'hB: brake_ms_of = 14'h03E8;
            4'hC: brake_ms_of = 14'h09C4;
            4'hD: brake_ms_of = 14'h1388;
            4'hE: brake_ms_of = 14'h2710;
            default: brake_ms_of = 14'h3A98;
        endcase
    end
endfunction

// Stop duty threshold in per-mille; zero means immediate.
function [9:0] stop_pm_of;
    input [2:0] code;
    begin
        case (code)
            3'h0: stop_pm_of = 10'h3E8;
            3'h1: stop_pm_of = 10'h1F4;
            3'h2: stop_pm_of = 10'h0FA;
            3'h3: stop_pm_of = 10'h096;
            3'h4: stop_pm_of = 10'h064;
            3'h5: stop_pm_of = 10'h04B;
            3'h6: stop_pm_of = 10'h032;
            default: stop_pm_of = 10'h019;
        endcase
    end
endfunction

// Switch duty threshold in per-mille: 12, 15, 18, 20 percent.
function [9:0] switch_pm_of;
    input [1:0] code;
    begin
        case (code)
            2'h0: switch_pm_of = 10'h078;
            2'h1: switch_pm_of = 10'h096;
            2'h2: switch_pm_of = 10'h0B4;
            default: switch_pm_of = 10'h0C8;
        endcase
    end
endfunction

// Integration threshold: 25 per code to 800, then 50, 100, 200 steps.
function [11:0] integ_thr_of;
    input [5:0] code;
    begin
        if (code <= 6'h20)
            integ_thr_of = {6'h00, code} * 12'h019;
        else if (code <= 6'h30)
            integ_thr_of = 12'h320 + {6'h00, code - 6'h20} * 12'h032;
        else if (code <= 6'h38)
            integ_thr_of = 12'h640 + {6'h00, code - 6'h30} * 12'h064;
        else
            integ_thr_of = 12'h960 + {6'h00, code - 6'h38} * 12'h0C8;
    end
endfunction

// Current code in units of 0.1 V, expressed in mV.
function [10:0] limit_mv_of;
    input [3:0] code;
    begin
        limit_mv_of = {7'h00, code} * 11'h064;
    end
endfunction

// ==========================================================================
// Register file.
reg [31:0] loop_setting_two_r; // Speed pulse, stop and limit setup.
reg [31:0] loop_setting_three_r; // Degauss and commutation setup.
reg [31:0] loop_setting_four_r; // Fast deceleration setup.

// Writes to mapped offsets; others are ignored.
always @(posedge mclk) begin
    if (rst) begin
        loop_setting_two_r <= `RST_LOOP_TWO;
        loop_setting_three_r <= `RST_LOOP_THREE;
        loop_setting_four_r <= `RST_LOOP_FOUR;
    end else if (ce && reg_we) begin
        case (reg_addr)
            `ADDR_LOOP_TWO: loop_setting_two_r <= reg_wdata;
            `ADDR_LOOP_THREE: loop_setting_three_r <= reg_wdata;
            `ADDR_LOOP_FOUR: loop_setting_four_r <= reg_wdata;
            default: ;
        endcase
    end
end

// Read data is registered; unmapped addresses read zero.
always @(posedge mclk) begin
    if (rst) begin
        reg_rdata <= `RDATA_NONE;
    end else if (ce && reg_re) begin
        case (reg_addr)
            `ADDR_LOOP_TWO: reg_rdata <= loop_setting_two_r;
            `ADDR_LOOP_THREE: reg_rdata <= loop_setting_three_r;
            `ADDR_LOOP_FOUR: reg_rdata <= loop_setting_four_r;
            default: reg_rdata <= `RDATA_NONE;
        endcase
    end
end

// ==========================================================================
// Speed pulse gating.
reg mode_allows; // Current loop phase may emit pulses.
wire emf_allows; // Speed still above the emf threshold or forced active.
wire pulse_enable; // Divider runs.

// Mode decides in which loop phase pulses appear.
always @* begin
    case (loop_setting_two_r[`F_SP_MODE])
        `SP_MODE_ALWAYS: mode_allows = 1'b1;
        `SP_MODE_CLOSED: mode_allows = closed_loop;
        `SP_MODE_FIRST: mode_allows = closed_loop || first_attempt;
        default: mode_allows = 1'b0;
    endcase
end

assign emf_allows = loop_setting_two_r[`F_SP_ACT] ||
    (emf_mv >= emf_mv_of(loop_setting_two_r[`F_SP_EMF]));
assign pulse_enable = motor_driven && mode_allows && emf_allows;

speed_pulse_divider #(
    .WIDTH(4)
) u_divider (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .enable(pulse_enable),
    .half_period_event(half_period_event),
    .divider_code(loop_setting_two_r[`F_SP_DIV]),
    .speed_pulse_output(speed_pulse_output)
);

// ==========================================================================
// Stop sequencer.
localparam ST_IDLE = 4'b0001; // Running, no stop pending.
localparam ST_WAIT = 4'b0010; // Waiting for duty to reach the threshold.
localparam ST_BRAKE = 4'b0100; // Stop action applied for the brake time.
localparam ST_DONE = 4'b1000; // Stop finished, held until released.

reg [3:0] state_r; // Sequencer state.
reg [3:0] state_nxt; // Next sequencer state.
reg by_pin_r; // Started by the brake pin.
reg [2:0] method_r; // Method latched at stop start.
reg [31:0] tick_r; // Cycle count within one millisecond.
reg [13:0] ms_r; // Milliseconds spent braking.
wire ms_tick; // Last cycle of a millisecond.
wire [9:0] wait_pm; // Active duty threshold.
wire brake_timed; // Brake time elapsed.

assign ms_tick = (tick_r == TICK_CYCLES - 1);
assign wait_pm = by_pin_r ? stop_pm_of(loop_setting_two_r[`F_BRAKE_DUTY])
    : stop_pm_of(loop_setting_two_r[`F_STOP_DUTY]);
assign brake_timed = ms_tick &&
    (ms_r + 1'b1 >= brake_ms_of(loop_setting_two_r[`F_STOP_TIME]));

// Hi-z and recirculation stop at once; braking and spin down wait for
// duty to reach the threshold, then hold for the brake time.
always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_IDLE: begin
            if (brake_pin || stop_request)
                state_nxt = ST_WAIT;
        end
        ST_WAIT: begin
            if (!brake_pin && !stop_request)
                state_nxt = ST_IDLE;
            else if (!by_pin_r && (method_r == `STOP_HIZ ||
                    method_r == `STOP_RECIRC))
                state_nxt = ST_DONE;
            else if (duty_pm <= wait_pm)
                state_nxt = ST_BRAKE;
        end
        ST_BRAKE: begin
            if (brake_timed)
                state_nxt = ST_DONE;
        end
        ST_DONE: begin
            if (!brake_pin && !stop_request)
                state_nxt = ST_IDLE;
        end
        default: state_nxt = ST_IDLE;
    endcase
end

// State, latched method and the millisecond timer.
always @(posedge mclk) begin
    if (rst) begin
        state_r <= ST_IDLE;
        by_pin_r <= 1'b0;
        method_r <= `STOP_HIZ;
        tick_r <= 32'h00000000;
        ms_r <= 14'h0000;
    end else if (ce) begin
        state_r <= state_nxt;
        if (state_r == ST_IDLE) begin
            by_pin_r <= brake_pin;
            method_r <= brake_pin ? `STOP_LOW_BRAKE
                : loop_setting_two_r[`F_STOP_METHOD];
        end
        if (state_r != ST_BRAKE || ms_tick)
            tick_r <= 32'h00000000;
        else
            tick_r <= tick_r + 1'b1;
        if (state_r != ST_BRAKE)
            ms_r <= 14'h0000;
        else if (ms_tick)
            ms_r <= ms_r + 1'b1;
    end
end

// Stage controls registered from the next state.
always @(posedge mclk) begin
    if (rst) begin
        stage_hiz <= 1'b0;
        stage_recirc <= 1'b0;
        stage_low_brake <= 1'b0;
        stage_high_brake <= 1'b0;
        stage_spin_down <= 1'b0;
        stop_done <= 1'b0;
    end else if (ce) begin
        stage_hiz <= (state_nxt == ST_DONE) && (method_r == `STOP_HIZ);
        stage_recirc <= (state_nxt == ST_DONE) && (method_r == `STOP_RECIRC);
        stage_low_brake <= (state_nxt == ST_BRAKE) && (method_r == `STOP_LOW_BRAKE);
        stage_high_brake <= (state_nxt == ST_BRAKE) && (method_r == `STOP_HIGH_BRAKE);
        stage_spin_down <= (state_nxt == ST_BRAKE) && (method_r == `STOP_SPIN_DOWN);
        stop_done <= (state_nxt == ST_DONE);
    end
end

// ==========================================================================
// Commutation method switch.
reg [3:0] low_samples; // Samples to leave integration.
reg [3:0] high_samples; // Samples to enter integration.

// Sample thresholds: 3, 4, 6, 8 low and 4, 6, 8, 10 high.
always @* begin
    case (loop_setting_three_r[`F_CYC_LOW])
        2'h0: low_samples = 4'h3;
        2'h1: low_samples = 4'h4;
        2'h2: low_samples = 4'h6;
        default: low_samples = 4'h8;
    endcase
    case (loop_setting_three_r[`F_CYC_HIGH])
        2'h0: high_samples = 4'h4;
        2'h1: high_samples = 4'h6;
        2'h2: high_samples = 4'h8;
        default: high_samples = 4'hA;
    endcase
end

// Integration only when the method bit asks, with hysteresis on
// samples and duty so the method does not chatter.
always @(posedge mclk) begin
    if (rst) begin
        on_integration <= 1'b0;
    end else if (ce) begin
        if (!loop_setting_three_r[`F_COMM_METHOD])
            on_integration <= 1'b0;
        else if (on_integration) begin
            if (samples_per_30 < {4'h0, low_samples} ||
                    duty_pm < switch_pm_of(loop_setting_three_r[`F_DUTY_LOW]))
                on_integration <= 1'b0;
        end else if (samples_per_30 > {4'h0, high_samples} &&
                duty_pm > switch_pm_of(loop_setting_three_r[`F_DUTY_HIGH]))
            on_integration <= 1'b1;
    end
end

// ==========================================================================
// Decoded settings and fast-deceleration current limit.
wire [10:0] limit_mv; // Per-cycle limit from its code.
wire [10:0] floor_mv; // Fast deceleration floor from its code.

assign limit_mv = limit_mv_of(loop_setting_two_r[`F_CYCLE_LIMIT]);
assign floor_mv = limit_mv_of(loop_setting_four_r[`F_FD_FLOOR]);

// Decoded settings, registered as data outputs.
always @(posedge mclk) begin
    if (rst) begin
        falling_integration_threshold <= 12'h000;
        rising_integration_threshold <= 12'h000;
        degauss_sample_count <= 3'h0;
        degauss_lower_mv <= 8'h00;
        degauss_upper_drop_mv <= 8'h00;
        comparator_blank <= 1'b0;
        fast_decel_window_pm <= 10'h000;
        fast_decel_threshold_pm <= 10'h000;
    end else if (ce) begin
        falling_integration_threshold <=
            integ_thr_of(loop_setting_three_r[`F_FALL_THR]);
        rising_integration_threshold <=
            integ_thr_of(loop_setting_three_r[`F_RISE_THR]);
        degauss_sample_count <= {1'b0, loop_setting_three_r[`F_DGS_COUNT]} + 3'h2;
        degauss_lower_mv <= ({6'h00, loop_setting_three_r[`F_DGS_LOWER]} + 8'h01)
            * 8'h1E;
        degauss_upper_drop_mv <= ({6'h00, loop_setting_three_r[`F_DGS_UPPER]} + 8'h03)
            * 8'h1E;
        comparator_blank <= loop_setting_four_r[`F_BLANK_EN] && fast_decel_active;
        fast_decel_window_pm <= (loop_setting_four_r[`F_FD_WINDOW] > 3'h4) ?
            {7'h00, loop_setting_four_r[`F_FD_WINDOW] - 3'h2} * 10'h032
            : {7'h00, loop_setting_four_r[`F_FD_WINDOW]} * 10'h019;
        fast_decel_threshold_pm <= 10'h3E8
            - {7'h00, loop_setting_four_r[`F_FD_THRESH]} * 10'h032;
    end
end

// The limit steps down 0.1 V per half-period in fast deceleration with
// reduction on, never below the floor; otherwise it is the per-cycle
// limit.
always @(posedge mclk) begin
    if (rst) begin
        current_limit_mv <= 11'h000;
    end else if (ce) begin
        if (!fast_decel_active || !loop_setting_four_r[`F_FD_REDUCE])
            current_limit_mv <= limit_mv;
        else if (half_period_event && current_limit_mv >= floor_mv + 11'h064)
            current_limit_mv <= current_limit_mv - 11'h064;
        else if (current_limit_mv < floor_mv)
            current_limit_mv <= floor_mv;
    end
end

endmodule // sensorless_bldc_loop_config

/* File: hw/loop_config_regs.vh */
/*
 * Register offsets, reset values, field ranges and timing constants of the
 * closed-loop configuration block.
 * Assumes an 8-bit byte-address register port and a 20 MHz clock.
 */
`ifndef LOOP_CONFIG_REGS_VH
`define LOOP_CONFIG_REGS_VH

// ==========================================================================
// Register offsets and reset values.
`define ADDR_LOOP_TWO 8'h88
`define ADDR_LOOP_THREE 8'h8A
`define ADDR_LOOP_FOUR 8'h8C
`define RST_LOOP_TWO 32'h00000000
`define RST_LOOP_THREE 32'h14000000
`define RST_LOOP_FOUR 32'h00000000
`define RDATA_NONE 32'h00000000

// ==========================================================================
// Fields of loop_setting_two.
`define F_SP_MODE 30:29
`define F_SP_DIV 28:25
`define F_SP_ACT 24
`define F_SP_EMF 23:21
`define F_STOP_METHOD 20:18
`define F_STOP_TIME 17:14
`define F_STOP_DUTY 13:11
`define F_BRAKE_DUTY 10:8
`define F_CYCLE_LIMIT 6:3

// ==========================================================================
// Fields of loop_setting_three.
`define F_DGS_COUNT 30:29
`define F_DGS_UPPER 28:27
`define F_DGS_LOWER 26:25
`define F_CYC_LOW 24:23
`define F_CYC_HIGH 22:21
`define F_DUTY_LOW 20:19
`define F_DUTY_HIGH 18:17
`define F_FALL_THR 16:11
`define F_RISE_THR 10:5
`define F_COMM_METHOD 4

// ==========================================================================
// Fields of loop_setting_four.
`define F_BLANK_EN 19
`define F_FD_WINDOW 18:16
`define F_FD_THRESH 15:13
`define F_FD_FLOOR 12:9
`define F_FD_REDUCE 8

// ==========================================================================
// Codes of the speed-pulse mode and stop method fields, and the divider's code-zero factor.
`define SP_MODE_ALWAYS 2'h0
`define SP_MODE_CLOSED 2'h1
`define SP_MODE_FIRST 2'h2
`define STOP_HIZ 3'h0
`define STOP_RECIRC 3'h1
`define STOP_LOW_BRAKE 3'h2
`define STOP_HIGH_BRAKE 3'h3
`define STOP_SPIN_DOWN 3'h4
`define DIV_CODE_ZERO_FACTOR 4'h3

// ==========================================================================
// Timing.
`define CLK_PERIOD_NS 50
`define MS_IN_NS 1000000

`endif

/* File: hw/speed_pulse_divider.v */
/*
 * Divides electrical half-period events into the speed pulse
 * square wave.
 * Assumes half_period_event is a one-cycle mclk pulse.
 */
`timescale 1ns/1ps
`include "loop_config_regs.vh"

module speed_pulse_divider #(
    parameter WIDTH = 4
) (
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire enable,
    input wire half_period_event,
    input wire [WIDTH-1:0] divider_code,
    output reg speed_pulse_output
);

// ==========================================================================
// Divider state.
reg [WIDTH-1:0] count_r; // Events seen since the last output toggle.
wire [WIDTH-1:0] factor; // Effective division factor.

// Code zero divides by three.
assign factor = (divider_code == {WIDTH{1'b0}}) ?
    `DIV_CODE_ZERO_FACTOR : divider_code;

// Toggles every factor half-periods: period is factor electrical
// periods; a disabled output idles low.
always @(posedge mclk) begin
    if (rst) begin
        count_r <= {WIDTH{1'b0}};
        speed_pulse_output <= 1'b0;
    end else if (ce) begin
        if (!enable) begin
            count_r <= {WIDTH{1'b0}};
            speed_pulse_output <= 1'b0;
        end else if (half_period_event) begin
            if (count_r + 1'b1 >= factor) begin
                count_r <= {WIDTH{1'b0}};
                speed_pulse_output <= ~speed_pulse_output;
            end else begin
                count_r <= count_r + 1'b1;
            end
        end
    end
end

endmodule // speed_pulse_divider

/* File: bench/motor_model.sv */
/* Behavioural motor as seen through the power stage.
   Assumes a free-running mclk; spin marks a turning rotor. */
`timescale 1ns/1ps
module motor_model (
    input wire mclk,
    input wire spin,
    output reg half_period_event = 1'b0,
    output reg [7:0] emf_mv = 8'h00
);
    reg [2:0] phase_r = 3'h0; // Cycle position inside one half period.
    // ====
    // A half period lasts six cycles; a still rotor gives no events and no emf.
    always @(posedge mclk) begin
        phase_r <= (spin && phase_r != 3'h5) ? phase_r + 3'h1 : 3'h0;
        half_period_event <= spin && phase_r == 3'h5;
        emf_mv <= spin ? 8'h28 : 8'h00;
    end
endmodule // motor_model

/* File: bench/sensorless_bldc_loop_config_monitor.sv */
/* Port checker of the loop configuration block.
   Assumes the block's port names; attached by the bind below. */
`timescale 1ns/1ps
module loop_config_monitor (
    input wire mclk,
    input wire rst,
    input wire [7:0] samples_per_30,
    input wire [9:0] duty_pm,
    input wire fast_decel_active,
    input wire stage_hiz,
    input wire stage_recirc,
    input wire stage_low_brake,
    input wire stage_high_brake,
    input wire stage_spin_down,
    input wire on_integration,
    input wire [2:0] degauss_sample_count,
    input wire [7:0] degauss_lower_mv,
    input wire [7:0] degauss_upper_drop_mv,
    input wire comparator_blank,
    input wire [9:0] fast_decel_window_pm,
    input wire [9:0] fast_decel_threshold_pm,
    input wire [10:0] current_limit_mv
);
    // ====
    // All checks run on mclk and rest while reset is high.
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    chk_stage_single: assert property (
        $onehot0({stage_hiz, stage_recirc, stage_low_brake, stage_high_brake, stage_spin_down}))
        else $error("stage overlap");
    chk_integ_entry: assert property (
        $rose(on_integration) |-> $past(samples_per_30) > 8'h04 && $past(duty_pm) > 10'h078)
        else $error("early integration");
    chk_count_range: assert property (
        !$past(rst) |-> degauss_sample_count inside {[3'h2:3'h5]}) else $error("bad count");
    chk_lower_table: assert property (
        !$past(rst) |-> degauss_lower_mv inside {8'h1E, 8'h3C, 8'h5A, 8'h78})
        else $error("bad lower bound");
    chk_upper_table: assert property (
        !$past(rst) |-> degauss_upper_drop_mv inside {8'h5A, 8'h78, 8'h96, 8'hB4})
        else $error("bad upper bound");
    chk_thresh_table: assert property (
        !$past(rst) |-> fast_decel_threshold_pm inside {[10'h28A:10'h3E8]}
        && fast_decel_threshold_pm % 10'h032 == 10'h000) else $error("bad threshold");
    chk_window_table: assert property (
        fast_decel_window_pm inside {10'h000, 10'h019, 10'h032, 10'h04B, 10'h064, 10'h096,
        10'h0C8, 10'h0FA}) else $error("bad window");
    chk_limit_grid: assert property (
        current_limit_mv % 11'h064 == 11'h000 && current_limit_mv <= 11'h5DC)
        else $error("bad limit");
    chk_blank_cause: assert property (
        comparator_blank |-> $past(fast_decel_active)) else $error("blank without decel");
endmodule // loop_config_monitor

bind sensorless_bldc_loop_config loop_config_monitor mon (.*);

/* File: bench/sensorless_bldc_loop_config_tb.sv */
/* Self-checking bench of the loop configuration block.
   Assumes the motor model, checker and register header. */
`timescale 1ns/1ps
`include "loop_config_regs.vh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin bad_count++; \
    $display("mismatch %s exp %0d got %0d", n, e, a); end end
module sensorless_bldc_loop_config_tb;
    // ====
    reg mclk = 1'b0, rst = 1'b1, ce = 1'b1, reg_we = 1'b0, reg_re = 1'b0, spin = 1'b0;
    reg closed_loop = 1'b0, first_attempt = 1'b0, motor_driven = 1'b0;
    reg stop_request = 1'b0, brake_pin = 1'b0, fast_decel_active = 1'b0;
    reg [7:0] reg_addr = 8'h00, samples_per_30 = 8'h00;
    reg [31:0] reg_wdata = 32'h0, d;
    reg [9:0] duty_pm = 10'h000;
    wire half_period_event, speed_pulse_output, stop_done, on_integration, comparator_blank;
    wire stage_hiz, stage_recirc, stage_low_brake, stage_high_brake, stage_spin_down;
    wire [31:0] reg_rdata;
    wire [7:0] emf_mv, degauss_lower_mv, degauss_upper_drop_mv;
    wire [11:0] falling_integration_threshold, rising_integration_threshold;
    wire [2:0] degauss_sample_count;
    wire [9:0] fast_decel_window_pm, fast_decel_threshold_pm;
    wire [10:0] current_limit_mv;
    wire [4:0] stage = {stage_spin_down, stage_high_brake, stage_low_brake, stage_recirc,
        stage_hiz};
    int bad_count = 0, compares = 0;
    // Brake counts shrink to four cycles per millisecond.
    sensorless_bldc_loop_config #(.TICK_CYCLES(4)) DUT (.*);
    motor_model motor (.*);
    initial forever #25 mclk = ~mclk;
    // ====
    // Register port cycles and a settle wait.
    task wr(input [7:0] a, input [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_we <= 1'b1;
        @(posedge mclk);
        reg_we <= 1'b0;
    endtask
    task rd(input [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge mclk);
        reg_re <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task st(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // ====
    // Scenarios.
    task t_regs;
        rd(`ADDR_LOOP_THREE);
        `CHK("three", `RST_LOOP_THREE, d)
        rd(`ADDR_LOOP_FOUR);
        `CHK("four", `RST_LOOP_FOUR, d)
        `CHK("thr", 1000, fast_decel_threshold_pm)
        wr(8'h90, 32'hFFFFFFFF);
        rd(8'h90);
        `CHK("unmapped", `RDATA_NONE, d)
        wr(`ADDR_LOOP_TWO, 32'hA5A5A5A5);
        rd(`ADDR_LOOP_TWO);
        `CHK("two", 32'hA5A5A5A5, d)
    endtask
    task t_tables;
        int e;
        for (int c = 0; c < 4; c++) begin
            wr(`ADDR_LOOP_THREE, {1'b0, c[1:0], c[1:0], c[1:0], 25'h0});
            st(2);
            `CHK("count", c + 2, degauss_sample_count)
            `CHK("upper", 90 + 30 * c, degauss_upper_drop_mv)
            `CHK("lower", 30 + 30 * c, degauss_lower_mv)
        end
        for (int c = 0; c < 64; c++) begin
            e = c <= 32 ? 25 * c : c <= 48 ? 800 + 50 * (c - 32) : c <= 56 ?
                1600 + 100 * (c - 48) : 2400 + 200 * (c - 56);
            wr(`ADDR_LOOP_THREE, {15'h0, c[5:0], c[5:0], 5'h0});
            st(2);
            `CHK("fall", e, falling_integration_threshold)
            `CHK("rise", e, rising_integration_threshold)
        end
    endtask
    task t_dec;
        for (int c = 0; c < 8; c++) begin
            wr(`ADDR_LOOP_FOUR, {12'h0, 1'b1, c[2:0], c[2:0], 4'h2, 1'b1, 8'h0});
            st(2);
            `CHK("win", c < 5 ? 25 * c : 50 * (c - 2), fast_decel_window_pm)
            `CHK("thr", 1000 - 50 * c, fast_decel_threshold_pm)
        end
        wr(`ADDR_LOOP_TWO, {25'h0, 4'h5, 3'h0});
        st(2);
        `CHK("limit", 500, current_limit_mv)
        @(posedge mclk) fast_decel_active <= 1'b1;
        spin <= 1'b1;
        st(40);
        `CHK("blank", 1'b1, comparator_blank)
        `CHK("floor", 200, current_limit_mv)
        @(posedge mclk) fast_decel_active <= 1'b0;
        spin <= 1'b0;
        st(3);
        `CHK("fixed", 500, current_limit_mv)
    endtask
    // Counts toggles against taken events; n of zero means no output.
    task automatic t_pulse(input [1:0] m, input [3:0] dv, input cl, input fa, input int n);
        int ev = 0, tg = 0;
        reg last = 1'b0;
        wr(`ADDR_LOOP_TWO, {1'b0, m, dv, 1'b1, 24'h0});
        closed_loop <= cl;
        first_attempt <= fa;
        motor_driven <= 1'b1;
        spin <= 1'b1;
        repeat (120) begin
            st(1);
            tg += speed_pulse_output !== last;
            last = speed_pulse_output;
            ev += half_period_event;
        end
        @(posedge mclk) motor_driven <= 1'b0;
        spin <= 1'b0;
        #1 tg += speed_pulse_output !== last;
        `CHK("pulses", n ? ev / n : 0, tg)
    endtask
    // Stage outputs until stop is done; cyc is the braking span.
    task automatic t_stop(input [2:0] m, input [3:0] tc, input int cyc);
        int k = 0;
        reg [4:0] seen = 5'h0;
        wr(`ADDR_LOOP_TWO, {11'h0, m, tc, 14'h0});
        stop_request <= 1'b1;
        repeat (100) begin
            st(1);
            seen |= stage;
            if (stop_done === 1'b1) break;
            k += stage != 5'h0;
        end
        `CHK("stage", 5'h1 << m, seen)
        `CHK("time", 1'b1, k >= cyc && k <= cyc + 1)
        @(posedge mclk) stop_request <= 1'b0;
        st(3);
        `CHK("idle", 1'b0, stop_done)
    endtask
    // Stop waits while duty sits above the threshold, then brakes.
    task t_gate(input [31:0] v, input pin, input [4:0] exp);
        wr(`ADDR_LOOP_TWO, v);
        duty_pm <= 10'h258;
        stop_request <= !pin;
        brake_pin <= pin;
        st(10);
        `CHK("hold", 5'h0, stage)
        @(posedge mclk) duty_pm <= 10'h014;
        st(3);
        `CHK("go", exp, stage)
        @(posedge mclk) stop_request <= 1'b0;
        brake_pin <= 1'b0;
        st(10);
    endtask
    task t_com(input [7:0] s, input [9:0] u, input e);
        @(posedge mclk) samples_per_30 <= s;
        duty_pm <= u;
        st(3);
        `CHK("integ", e, on_integration)
    endtask
    task tally_and_finish;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ====
    // Main sequence and watchdog.
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        t_regs;
        t_tables;
        t_dec;
        t_pulse(2'h0, 4'h2, 1'b0, 1'b0, 2);
        t_pulse(2'h0, 4'h0, 1'b1, 1'b0, 3);
        t_pulse(2'h1, 4'h1, 1'b0, 1'b0, 0);
        t_pulse(2'h1, 4'hF, 1'b1, 1'b0, 15);
        t_pulse(2'h2, 4'h1, 1'b0, 1'b1, 1);
        t_pulse(2'h2, 4'h1, 1'b0, 1'b0, 0);
        t_pulse(2'h3, 4'h1, 1'b1, 1'b1, 0);
        for (int m = 0; m < 5; m++)
            t_stop(m[2:0], m[3:0], m < 2 ? 0 : m == 2 ? 20 : m == 3 ? 40 : 60);
        t_gate({11'h0, 3'h3, 4'h0, 3'h1, 11'h0}, 1'b0, 5'h08);
        t_gate({18'h0, 3'h0, 3'h7, 8'h0}, 1'b1, 5'h04);
        wr(`ADDR_LOOP_THREE, 32'h147E0010);
        t_com(8'h0A, 10'h0FA, 1'b0);
        t_com(8'h0B, 10'h0C8, 1'b0);
        t_com(8'h0B, 10'h0FA, 1'b1);
        t_com(8'h0B, 10'h0BE, 1'b0);
        t_com(8'h0B, 10'h0FA, 1'b1);
        t_com(8'h02, 10'h0FA, 1'b0);
        wr(`ADDR_LOOP_THREE, 32'h147E0000);
        t_com(8'h0B, 10'h0FA, 1'b0);
        tally_and_finish;
    end
    initial begin
        #1000000;
        bad_count++;
        tally_and_finish;
    end
endmodule // sensorless_bldc_loop_config_tb
